/* rtl/adcr_defines.svh */
// Register offsets, field positions and reset values of the converter block.
`ifndef ADCR_DEFINES_SVH
`define ADCR_DEFINES_SVH

// Byte offsets on the register bus.
`define ADCR_OFF_CTL_ONE    8'h00
`define ADCR_OFF_CTL_TWO    8'h04
`define ADCR_OFF_CTL_THREE  8'h08
`define ADCR_OFF_STATUS     8'h0c
`define ADCR_OFF_SLOT0      8'h10
`define ADCR_OFF_SLOT1      8'h14
`define ADCR_OFF_SLOT2      8'h18
`define ADCR_OFF_SLOT3      8'h1c
`define ADCR_OFF_PIN_SEL    8'h20
`define ADCR_OFF_PORT_IN    8'h24
`define ADCR_OFF_IRQ_STAT   8'h28
`define ADCR_OFF_IRQ_MASK   8'h2c

// Field positions.
`define ADCR_B_ENABLE   0
`define ADCR_B_REFSEL   1
`define ADCR_B_CONT     4
`define ADCR_B_SCAN     5
`define ADCR_B_START    7
`define ADCR_B_EOC      0
`define ADCR_B_BUSY     1
`define ADCR_B_OVF      2
`define ADCR_B_PTR      4
`define ADCR_B_DELAY    3
`define ADCR_B_EV_EOC   0
`define ADCR_B_EV_OVF   1

// Reset values.
`define ADCR_RST_PTR    2'h3
`define ADCR_RST_BYTE   8'h00
`define ADCR_RST_IRQ    2'h0

// Extra bus cycles spent on a port read so the pin synchroniser refills.
`define ADCR_PORT_WAIT  2'h2
// Largest codes used for the divider and the sampling wait.
`define ADCR_CDIV_MAX   3'h5
`define ADCR_DELAY_MAX  3'h6

`endif

/* rtl/adcr_pkg.sv */
// Types shared by the converter control block.
package adcr_pkg;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } adcr_state_type;

  // Whole state of the sampling timer.
  typedef struct packed {
    logic       active;
    logic [4:0] div_cnt;
    logic [6:0] tick_cnt;
  } adcr_tmr_type;

  // Whole state of the top module except the wait timer's.
  typedef struct packed {
    adcr_state_type  state;
    logic            enable;
    logic            refsel;
    logic [2:0]      channel;
    logic            cont;
    logic            scan;
    logic            start;
    logic [2:0]      cdiv;
    logic [2:0]      delay;
    logic            eoc;
    logic            ovf;
    logic [1:0]      ptr;
    logic [3:0]      full;
    logic [7:0]      pin_sel;
    logic [1:0]      irq_st;
    logic [1:0]      irq_mask;
    logic [2:0]      cur_chan;
    logic [1:0]      burst;
    logic            go;
    logic            ack;
    logic [1:0]      wcnt;
    logic [31:0]     dat;
    logic [7:0]      pin_s1;
    logic [7:0]      pin_s2;
    logic [3:0][7:0] slot;
  } adcr_state_reg_type;

endpackage

/* rtl/adcr_sample_timer.sv */
// Sampling-wait timer counted in conversion-clock periods.
`timescale 1ns/1ps
`include "adcr_defines.svh"

module adcr_sample_timer
  import adcr_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control from the sequencer.
  input  wire logic       start_i,
  input  wire logic [2:0] cdiv_i,
  input  wire logic [2:0] delay_i,
  // End of the sampling wait.
  output logic            done_o
);

  adcr_tmr_type t_r;   // Registered timer state.
  adcr_tmr_type t_nxt; // Next timer state.
  logic [2:0]   cdiv_eff;  // Divider code with reserved codes clamped.
  logic [2:0]   delay_eff; // Wait code with the reserved code clamped.
  logic [4:0]   div_last;  // Last count of one conversion-clock period.
  logic [6:0]   wait_last; // Last conversion-clock period of the wait.
  logic         tick;      // One conversion-clock period has elapsed.

  // Reserved codes fall back to the longest legal setting.
  assign cdiv_eff  = (cdiv_i > `ADCR_CDIV_MAX) ? `ADCR_CDIV_MAX : cdiv_i;
  assign delay_eff = (delay_i > `ADCR_DELAY_MAX) ? `ADCR_DELAY_MAX : delay_i;

  // Codes 0 to 6 give 1, 2, 4 ... 64 conversion-clock periods.
  assign div_last  = 5'((6'h01 << cdiv_eff) - 6'h01);
  assign wait_last = 7'((8'h01 << delay_eff) - 8'h01);

  assign tick   = t_r.active && (t_r.div_cnt == div_last);
  assign done_o = tick && (t_r.tick_cnt == wait_last);

  // Next state: a start restarts the count from the selection moment.
  always_comb begin
    t_nxt = t_r;
    if (start_i) begin
      t_nxt.active   = 1'b1;
      t_nxt.div_cnt  = 5'h00;
      t_nxt.tick_cnt = 7'h00;
    end else if (t_r.active) begin
      if (tick) begin
        t_nxt.div_cnt = 5'h00;
        if (done_o) begin
          t_nxt.active = 1'b0;
        end else begin
          t_nxt.tick_cnt = t_r.tick_cnt + 7'h01;
        end
      end else begin
        t_nxt.div_cnt = t_r.div_cnt + 5'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

endmodule

/* rtl/adcr_top.sv */
// Converter control: sampling sequence, result slots and register bus.
// Notes on behaviour
// - Wait codes 0-6 give 1..64 clocks.
// - Four byte result slots, read only.
// - Burst results fill slots zero to three.
// - Results have no power-up initial value.
// - Warm reset keeps result contents.
// - Reference off whenever converter disabled.
// - Per-pin bit picks digital or analog.
// - Digital buffers open only on port reads.
// - Sample from selection until hold point.
// - Wait counts from start or previous end.
// - Unread slot rewritten sets overrun, continues.
// - Pointer shows last slot, forced on start.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "adcr_defines.svh"

module adcr_top
  import adcr_pkg::*;
(
  // Clock and warm reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Interrupt.
  output logic             irq_o,
  // Analog converter core.
  output logic [2:0]       mux_sel_o,
  output logic             sample_o,
  output logic             conv_start_o,
  input  wire logic        conv_done_i,
  input  wire logic [7:0]  conv_data_i,
  output logic             adc_power_o,
  output logic             ref_on_o,
  // Shared input pins.
  input  wire logic [7:0]  pin_d_i,
  input  wire logic        idle_mode_i,
  output logic [7:0]       pin_analog_o,
  output logic [7:0]       pin_inbuf_en_o
);

  // All block state except the wait timer's lives in one packed record, registered by one process.
  adcr_state_reg_type s_r;   // Registered block state.
  adcr_state_reg_type s_nxt; // Next block state.
  logic       tmr_start;     // Restart the sampling wait.
  logic       tmr_done;      // Sampling wait elapsed.
  logic       req;           // A bus request awaits its answer.
  logic       take;          // The request is taken this cycle; its ack goes out next cycle.
  logic       wr;            // Write takes effect this cycle.
  logic       port_req;      // A read of the port input is pending.
  logic [1:0] slot_idx;      // Slot that the next result goes to.
  logic       last;          // This result ends the run or burst.
  logic [7:0] wb;            // Low byte of the write data.

  // The wait timer sits beside the sequencer.
  adcr_sample_timer u_tmr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tmr_start),
    .cdiv_i  (s_r.cdiv),
    .delay_i (s_r.delay),
    .done_o  (tmr_done)
  );

  // A request whose ack is in flight is not taken a second time.
  assign wb       = dat_i[7:0];
  assign req      = cyc_i && stb_i && !s_r.ack;
  assign port_req = req && !we_i && (adr_i == `ADCR_OFF_PORT_IN);
  // The next slot follows the pointer, so slot three wraps to zero.
  assign slot_idx = s_r.ptr + 2'h1;
  // A single conversion always ends its run; a scan ends after four.
  assign last     = !s_r.scan || (s_r.burst == 2'h3);

  // Next-state logic: bus, sequencer, flags, in rising priority.
  always_comb begin
    s_nxt     = s_r;
    tmr_start = 1'b0;
    take      = 1'b0;
    wr        = 1'b0;
    // Pulses last one cycle unless they are set again below.
    s_nxt.go  = 1'b0;
    s_nxt.ack = 1'b0;

    // Pins pass two flip-flops before anything reads them.
    // The first stage may go metastable, so only the second is read.
    s_nxt.pin_s1 = pin_d_i;
    s_nxt.pin_s2 = s_r.pin_s1;

    // Port reads wait until the synchroniser holds opened-buffer data.
    // Every other request is answered one cycle after it is seen.
    if (req) begin
      if (!port_req || (s_r.wcnt == `ADCR_PORT_WAIT)) begin
        take       = 1'b1;
        s_nxt.ack  = 1'b1;
        s_nxt.wcnt = 2'h0;
      end else begin
        s_nxt.wcnt = s_r.wcnt + 2'h1;
      end
    end
    // Only the low byte lane carries register data.
    wr = take && we_i && sel_i[0];

    // Read data; unmapped addresses read zero.
    if (take && !we_i) begin
      s_nxt.dat = 32'h0000_0000;
      unique case (adr_i)
        // Enable and reference select.
        `ADCR_OFF_CTL_ONE: begin
          s_nxt.dat[`ADCR_B_ENABLE] = s_r.enable;
          s_nxt.dat[`ADCR_B_REFSEL] = s_r.refsel;
        end
        // Channel, mode bits and the live start bit.
        `ADCR_OFF_CTL_TWO: begin
          s_nxt.dat[2:0]           = s_r.channel;
          s_nxt.dat[`ADCR_B_CONT]  = s_r.cont;
          s_nxt.dat[`ADCR_B_SCAN]  = s_r.scan;
          s_nxt.dat[`ADCR_B_START] = s_r.start;
        end
        // Divider and sampling-wait codes as written, reserved ones too.
        `ADCR_OFF_CTL_THREE: begin
          s_nxt.dat[2:0] = s_r.cdiv;
          s_nxt.dat[`ADCR_B_DELAY +: 3] = s_r.delay;
        end
        // Busy is derived from the sequencer, not stored.
        `ADCR_OFF_STATUS: begin
          s_nxt.dat[`ADCR_B_EOC]  = s_r.eoc;
          s_nxt.dat[`ADCR_B_BUSY] = (s_r.state != ST_IDLE);
          s_nxt.dat[`ADCR_B_OVF]  = s_r.ovf;
          s_nxt.dat[`ADCR_B_PTR +: 2] = s_r.ptr;
        end
        // Reading a slot marks it as taken by software.
        `ADCR_OFF_SLOT0, `ADCR_OFF_SLOT1,
        `ADCR_OFF_SLOT2, `ADCR_OFF_SLOT3: begin
          s_nxt.dat[7:0] = s_r.slot[adr_i[3:2]];
          s_nxt.full[adr_i[3:2]] = 1'b0;
        end
        // Function select reads back as written.
        `ADCR_OFF_PIN_SEL:  s_nxt.dat[7:0] = s_r.pin_sel;
        // Analog pins read zero through the port.
        `ADCR_OFF_PORT_IN:  s_nxt.dat[7:0] = s_r.pin_s2 & ~s_r.pin_sel;
        // Interrupt status and mask share one layout.
        `ADCR_OFF_IRQ_STAT: s_nxt.dat[1:0] = s_r.irq_st;
        `ADCR_OFF_IRQ_MASK: s_nxt.dat[1:0] = s_r.irq_mask;
        // Anything else reads zero, so software never sees stale data.
        default:            s_nxt.dat = 32'h0000_0000;
      endcase
    end

    // Register writes; slots and the port ignore writes.
    if (wr) begin
      unique case (adr_i)
        // Clearing enable aborts a run further down.
        `ADCR_OFF_CTL_ONE: begin
          s_nxt.enable = wb[`ADCR_B_ENABLE];
          s_nxt.refsel = wb[`ADCR_B_REFSEL];
        end
        // Mode bits should only change while start is low.
        `ADCR_OFF_CTL_TWO: begin
          s_nxt.channel = wb[2:0];
          s_nxt.cont    = wb[`ADCR_B_CONT];
          s_nxt.scan    = wb[`ADCR_B_SCAN];
          s_nxt.start   = wb[`ADCR_B_START] && s_r.enable;
          // A rising start launches a run from the selected channel.
          // A write with start already high changes nothing here.
          if (s_nxt.start && !s_r.start) begin
            s_nxt.ptr      = `ADCR_RST_PTR;
            s_nxt.eoc      = 1'b0;
            s_nxt.cur_chan = wb[2:0];
            s_nxt.burst    = 2'h0;
            s_nxt.state    = ST_SAMPLE;
            tmr_start      = 1'b1;
          end
        end
        // Codes should change only while the converter is off.
        `ADCR_OFF_CTL_THREE: begin
          s_nxt.cdiv  = wb[2:0];
          s_nxt.delay = wb[`ADCR_B_DELAY +: 3];
        end
        // Flags clear on a written one; a zero leaves them alone.
        `ADCR_OFF_STATUS: begin
          if (wb[`ADCR_B_EOC]) s_nxt.eoc = 1'b0;
          if (wb[`ADCR_B_OVF]) s_nxt.ovf = 1'b0;
        end
        `ADCR_OFF_PIN_SEL:  s_nxt.pin_sel  = wb;
        // Interrupt status bits clear on a written one.
        `ADCR_OFF_IRQ_STAT: s_nxt.irq_st   = s_r.irq_st & ~wb[1:0];
        `ADCR_OFF_IRQ_MASK: s_nxt.irq_mask = wb[1:0];
        // Unmapped and read-only offsets swallow the write.
        default:            s_nxt.irq_mask = s_nxt.irq_mask;
      endcase
    end

    // Sequencer; its flag sets come after the clears so sets win.
    // A cleared start ends a run only after a done pulse; clearing enable aborts it even in mid-conversion.
    unique case (s_r.state)
      // Nothing runs until a rising start is written.
      ST_IDLE: begin
        s_nxt.burst = s_nxt.burst;
      end
      // Input stays selected and tracking until the hold point.
      ST_SAMPLE: begin
        if (tmr_done) begin
          s_nxt.go    = 1'b1;
          s_nxt.state = ST_CONVERT;
        end
      end
      // The core answers the hold pulse with a one-cycle done pulse.
      ST_CONVERT: begin
        if (conv_done_i) begin
          // Store in order, overwriting an unread slot.
          s_nxt.slot[slot_idx] = conv_data_i;
          s_nxt.ptr            = slot_idx;
          s_nxt.full[slot_idx] = 1'b1;
          if (s_r.full[slot_idx]) begin
            s_nxt.ovf = 1'b1;
            s_nxt.irq_st[`ADCR_B_EV_OVF] = 1'b1;
          end
          // End of run: the result set is now safe to read.
          if (last) begin
            s_nxt.eoc = 1'b1;
            s_nxt.irq_st[`ADCR_B_EV_EOC] = 1'b1;
          end
          // A cleared start lets this conversion finish, then stops.
          if (!s_nxt.start || (last && !s_r.cont)) begin
            s_nxt.start = 1'b0;
            s_nxt.state = ST_IDLE;
          end else begin
            // Next wait counts from this completion.
            s_nxt.state    = ST_SAMPLE;
            tmr_start      = 1'b1;
            s_nxt.burst    = last ? 2'h0 : s_r.burst + 2'h1;
            s_nxt.cur_chan = last ? s_r.channel : s_r.cur_chan + 3'h1;
          end
        end
      end
      // The fourth encoding is unused; fall back to idle.
      default: s_nxt.state = ST_IDLE;
    endcase

    // Disabling aborts the run and clears the run flags.
    // For these fields it wins over anything else decided in the same cycle.
    if (!s_nxt.enable) begin
      s_nxt.state = ST_IDLE;
      s_nxt.start = 1'b0;
      s_nxt.eoc   = 1'b0;
      s_nxt.ovf   = 1'b0;
      s_nxt.go    = 1'b0;
    end
  end

  // State register; warm reset leaves the slots as they were.
  // Slots get no power-up value, so they may start unknown.
  // The record is cleared first and named fields then take their values.
  // Reset is synchronous, so holding the slots needs no special cell.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.state    <= ST_IDLE;
      s_r.ptr      <= `ADCR_RST_PTR;
      s_r.pin_sel  <= `ADCR_RST_BYTE;
      s_r.irq_st   <= `ADCR_RST_IRQ;
      s_r.irq_mask <= `ADCR_RST_IRQ;
      s_r.slot     <= s_r.slot;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs.
  // Each is a flip-flop or a plain gate of flip-flops, except the buffers.
  assign dat_o        = s_r.dat;
  assign ack_o        = s_r.ack;
  // A level that stays while any unmasked status bit is set.
  assign irq_o        = |(s_r.irq_st & s_r.irq_mask);
  assign mux_sel_o    = s_r.cur_chan;
  assign sample_o     = (s_r.state == ST_SAMPLE);
  assign conv_start_o = s_r.go;
  assign adc_power_o  = s_r.enable;
  // Reference follows the select only while enabled.
  assign ref_on_o     = s_r.enable && s_r.refsel;
  assign pin_analog_o = s_r.pin_sel;

  // Digital buffers open only for a port read, never when idle.
  // One gate per pin; analog pins never open their digital buffer.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_buf
      assign pin_inbuf_en_o[gi] = port_req && !idle_mode_i &&
                                  !s_r.pin_sel[gi];
    end
  endgenerate

endmodule

/* bench/adcr_assertions.sv */
// Port checks of the converter control block.
`timescale 1ns/1ps
`include "adcr_defines.svh"
module adcr_assertions (
  // Clock, reset and bus.
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       we_i,
  input wire logic [7:0] adr_i,
  input wire logic       ack_o,
  // Converter and pins.
  input wire logic [2:0] mux_sel_o,
  input wire logic       sample_o,
  input wire logic       conv_start_o,
  input wire logic       adc_power_o,
  input wire logic       ref_on_o,
  input wire logic       idle_mode_i,
  input wire logic [7:0] pin_analog_o,
  input wire logic [7:0] pin_inbuf_en_o
);
  logic [11:0] scnt_r;  // Sampling cycles so far.
  logic        rd_port; // A port read is on the bus.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign rd_port = cyc_i && stb_i && !we_i && adr_i == `ADCR_OFF_PORT_IN;
  // Cleared outside sampling, so at the hold pulse it holds the length.
  always_ff @(posedge clk_i) begin
    if (rst_i || !sample_o) scnt_r <= 12'h000;
    else scnt_r <= scnt_r + 12'h001;
  end
  property p_ref; ref_on_o |-> adc_power_o; endproperty
  a_ref: assert property (p_ref) else $error("ref on");
  property p_off;
    !adc_power_o && !$past(adc_power_o) |-> !sample_o && !conv_start_o;
  endproperty
  a_off: assert property (p_off) else $error("runs while off");
  property p_an; (pin_inbuf_en_o & pin_analog_o) == 8'h00; endproperty
  a_an: assert property (p_an) else $error("analog buffer open");
  property p_rd;
    pin_inbuf_en_o != 8'h00 |-> rd_port && !idle_mode_i;
  endproperty
  a_rd: assert property (p_rd) else $error("buffer open");
  property p_on;
    rd_port && !idle_mode_i && !ack_o |-> pin_inbuf_en_o == ~pin_analog_o;
  endproperty
  a_on: assert property (p_on) else $error("buffer shut");
  property p_hold; conv_start_o |-> $past(sample_o) && !sample_o;
  endproperty
  a_hold: assert property (p_hold) else $error("hold early");
  // A wait that is not a power of two means a wrong code decode.
  property p_len;
    conv_start_o |-> scnt_r != 12'h000
      && (scnt_r & (scnt_r - 12'h001)) == 12'h000;
  endproperty
  a_len: assert property (p_len) else $error("bad wait");
  property p_mux;
    sample_o && $past(sample_o) || conv_start_o |-> $stable(mux_sel_o);
  endproperty
  a_mux: assert property (p_mux) else $error("mux moved");
  c_hold: cover property (conv_start_o);
  c_buf: cover property (pin_inbuf_en_o != 8'h00);
  c_ref: cover property (ref_on_o);
endmodule
bind adcr_top adcr_assertions i_adcr_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .ack_o(ack_o), .mux_sel_o(mux_sel_o),
  .sample_o(sample_o), .conv_start_o(conv_start_o),
  .adc_power_o(adc_power_o), .ref_on_o(ref_on_o),
  .idle_mode_i(idle_mode_i), .pin_analog_o(pin_analog_o),
  .pin_inbuf_en_o(pin_inbuf_en_o)
);

/* bench/adcr_core_model.sv */
// Behavioural analog core answering each hold pulse with a result.
`timescale 1ns/1ps
module adcr_core_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Channel and hold pulse.
  input  wire logic [2:0] mux_sel_i,
  input  wire logic       conv_start_i,
  // Result.
  output logic            conv_done_o,
  output logic [7:0]      conv_data_o
);
  logic       busy_r; // Conversion running.
  logic [2:0] left_r; // Cycles still to wait.
  logic [2:0] chan_r; // Channel held at the hold point.
  logic       fire;   // Result goes out now.
  assign fire = busy_r && left_r == 3'h0;
  // Odd channels answer slowly; data is garbage outside the result.
  always @(posedge clk_i) begin
    if (rst_i) begin
      conv_done_o <= 1'b0;
      conv_data_o <= 8'h00;
      busy_r      <= 1'b0;
    end else begin
      conv_done_o <= fire;
      conv_data_o <= fire ? {5'h15, chan_r} : ~conv_data_o;
      if (fire) busy_r <= 1'b0;
      else if (conv_start_i) begin
        busy_r <= 1'b1;
        chan_r <= mux_sel_i;
        left_r <= {mux_sel_i[0], 2'b10};
      end else if (busy_r) left_r <= left_r - 3'h1;
    end
  end
endmodule

/* bench/tb.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`include "adcr_defines.svh"
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic        idle_mode_i = 1'b0;
  logic [7:0]  pin_d_i = 8'h00;
  logic [31:0] dat_o, q;
  logic        ack_o, irq_o, sample_o, conv_start_o, conv_done_i;
  logic        adc_power_o, ref_on_o;
  logic [2:0]  mux_sel_o;
  logic [7:0]  conv_data_i, pin_analog_o, pin_inbuf_en_o;
  logic [3:0]  sel_i = 4'hf; // Byte lanes on the bus.
  logic [3:0]  wsel = 4'hf;  // Byte lanes of the next request.
  int          num_errors = 0;
  int          comparisons = 0;
  int          scnt = 0;  // Sampling cycles counted.
  int          slen = 0;  // Length of the last sampling wait.
  int          ndone = 0; // Results sent by the core model.
  int          i, n;
  adcr_top i_adcr_top (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .mux_sel_o(mux_sel_o),
    .sample_o(sample_o), .conv_start_o(conv_start_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .adc_power_o(adc_power_o), .ref_on_o(ref_on_o), .pin_d_i(pin_d_i),
    .idle_mode_i(idle_mode_i), .pin_analog_o(pin_analog_o),
    .pin_inbuf_en_o(pin_inbuf_en_o)
  );
  adcr_core_model i_adcr_core_model (
    .clk_i(clk_i), .rst_i(rst_i), .mux_sel_i(mux_sel_o),
    .conv_start_i(conv_start_o), .conv_done_o(conv_done_i),
    .conv_data_o(conv_data_i)
  );
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Measures each sampling wait and counts results.
  always @(posedge clk_i) begin
    if (conv_start_o) begin
      slen <= scnt;
      scnt <= 0;
    end else if (sample_o) scnt <= scnt + 1;
    if (conv_done_i) ndone <= ndone + 1;
  end
  // One classic cycle; holds everything until ack is sampled.
  task automatic bus(input logic w, input logic [7:0] a, d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= wsel;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && t < 50) begin
      @(posedge clk_i);
      t++;
    end
    if (t == 50) num_errors++;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask
  task automatic rc(input string s, input logic [7:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(s, e, q);
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d);
  endtask
  // Polls a status bit; software trusts results only after the flag.
  task automatic poll(input int b, input logic v);
    int t;
    t = 0;
    bus(1'b0, `ADCR_OFF_STATUS, 8'h00);
    while (q[b] !== v && t < 300) begin
      bus(1'b0, `ADCR_OFF_STATUS, 8'h00);
      t++;
    end
    if (t == 300) begin
      $display("BAD poll bit %0d expected %b seen %b", b, v, q[b]);
      num_errors++;
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rc("status", `ADCR_OFF_STATUS, 32'h30);
    // Write zero to the slots; they are read-only, so nothing lands.
    for (i = 0; i < 4; i++) wr(`ADCR_OFF_SLOT0 + 8'(4 * i), 8'h00);
    wr(`ADCR_OFF_CTL_ONE, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("ref off", 32'h0, {adc_power_o, ref_on_o});
    wr(`ADCR_OFF_CTL_ONE, 8'h03);
    repeat (2) @(posedge clk_i);
    chk("ref on", 32'h3, {adc_power_o, ref_on_o});
    // A write without the low byte lane must change nothing.
    wsel = 4'he;
    wr(`ADCR_OFF_CTL_ONE, 8'h00);
    wsel = 4'hf;
    rc("sel lane", `ADCR_OFF_CTL_ONE, 32'h3);
    pin_d_i <= 8'h5a;
    wr(`ADCR_OFF_PIN_SEL, 8'h0f);
    rc("port", `ADCR_OFF_PORT_IN, 32'h50);
    chk("analog", 32'h0f, pin_analog_o);
    idle_mode_i <= 1'b1;
    bus(1'b0, `ADCR_OFF_PORT_IN, 8'h00);
    idle_mode_i <= 1'b0;
    wr(8'h40, 8'h77);
    rc("unmapped", 8'h40, 32'h0);
    // Every wait code, then the largest divider with the shortest wait.
    for (i = 0; i < 9; i++) begin
      wr(`ADCR_OFF_CTL_ONE, 8'h00);
      n = i < 8 ? i * 8 : 5;
      wr(`ADCR_OFF_CTL_THREE, n[7:0]);
      wr(`ADCR_OFF_CTL_ONE, 8'h01);
      wr(`ADCR_OFF_CTL_TWO, {5'b10000, i[2:0]});
      poll(`ADCR_B_EOC, 1'b1);
      chk("wait", i < 7 ? 1 << i : (i == 7 ? 64 : 32), slen);
      rc("slot0", `ADCR_OFF_SLOT0, {5'h15, i[2:0]});
      rc("status", `ADCR_OFF_STATUS, 32'h01);
    end
    wr(`ADCR_OFF_CTL_TWO, 8'ha2);
    poll(`ADCR_B_EOC, 1'b1);
    rc("status", `ADCR_OFF_STATUS, 32'h31);
    wr(`ADCR_OFF_SLOT0, 8'h55);
    for (i = 0; i < 4; i++) begin
      rc("slot", `ADCR_OFF_SLOT0 + 8'(4 * i), {5'h15, 3'(i + 2)});
    end
    // Continuous run past four unread slots must wrap and overrun.
    n = ndone;
    wr(`ADCR_OFF_CTL_TWO, 8'h91);
    for (i = 0; i < 3000 && ndone - n < 5; i++) @(posedge clk_i);
    wr(`ADCR_OFF_CTL_TWO, 8'h11);
    poll(`ADCR_B_BUSY, 1'b0);
    n = ndone - n;
    bus(1'b0, `ADCR_OFF_STATUS, 8'h00);
    chk("ovf ptr", {26'h0, 2'(n - 1), 4'h4}, q & 32'h34);
    chk("irq masked", 32'h0, irq_o);
    wr(`ADCR_OFF_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h1, irq_o);
    wr(`ADCR_OFF_IRQ_STAT, 8'h03);
    repeat (2) @(posedge clk_i);
    chk("irq clear", 32'h0, irq_o);
    // A continuous run on one channel leaves its code in every slot.
    for (i = 0; i < 4; i++) begin
      rc("slot", `ADCR_OFF_SLOT0 + 8'(4 * i), 32'ha9);
    end
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rc("kept", `ADCR_OFF_SLOT0 + 8'(4 * i), 32'ha9);
    end
    rc("status", `ADCR_OFF_STATUS, 32'h30);
    chk("power", 32'h0, adc_power_o);
    summarize;
  end
endmodule
